// ---- design/mcct_top.sv ----
// Three counter-timer instances behind one strobe register port with one interrupt line.
// Assumes capture inputs are synchronous to clk and reads are answered one cycle later.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module mcct_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [mcct_pkg::MCCT_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [mcct_pkg::MCCT_NUM_INST-1:0] capture_in,
    output logic [mcct_pkg::MCCT_NUM_INST*mcct_pkg::MCCT_NUM_MATCH-1:0] match_out,
    output logic irq
);
    import mcct_pkg::*;

    logic [5:0] ofs;
    logic [1:0] inst_sel;
    logic [31:0] inst_rdata [MCCT_NUM_INST];
    logic [MCCT_NUM_INST-1:0] inst_irq;
    logic [31:0] next_rdata;

    assign ofs = addr[5:0];
    assign inst_sel = addr[MCCT_ADDR_W-1:MCCT_INST_LSB];

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    for (genvar g = 0; g < MCCT_NUM_INST; g++)
    begin : g_inst
        // The last instance is the narrow one; its upper register bits read as zero.
        localparam int W = (g == MCCT_NARROW_INST) ? MCCT_NARROW : MCCT_WIDE;

        logic sel_wr;
        logic en;
        logic clr;
        logic [31:0] wd;
        logic [31:0] prescale;
        logic [31:0] match_val [MCCT_NUM_MATCH];
        logic [11:0] match_ctl;
        logic [2:0] cap_ctl;
        logic [7:0] ext_ctl;
        logic ext_load;
        logic [STS_W-1:0] sts;
        logic [STS_W-1:0] msk;
        logic [STS_W-1:0] sts_set;
        logic [MCCT_NUM_MATCH-1:0] int_opt;
        logic [MCCT_NUM_MATCH*W-1:0] match_flat;
        logic [W-1:0] count;
        logic [W-1:0] pre_count;
        logic [W-1:0] cap_val;
        logic [MCCT_NUM_MATCH-1:0] match_hit;
        logic stop_hit;
        logic capture_hit;
        logic [MCCT_NUM_MATCH-1:0] pin_state;

        assign sel_wr = wr && (inst_sel == 2'(g));
        assign wd = wdata & mcct_width_mask(W);
        assign ext_load = sel_wr && (ofs == OFS_EXT_CTL);

        for (genvar i = 0; i < MCCT_NUM_MATCH; i++)
        begin : g_flat
            assign match_flat[i*W +: W] = match_val[i][W-1:0];
            assign int_opt[i] = mcct_mctl_bit(match_ctl, i, MCTL_INT);
        end

        // --------------------------------------------------------
        // Control register
        // --------------------------------------------------------
        // A stop match and a software write in one cycle: the stop wins, so a halted
        // counter is never restarted by a write that software issued before it saw the stop.
        always_ff @(posedge clk)
        begin
            if (!rst_b)
                en <= 1'b0;
            else if (stop_hit)
                en <= 1'b0;
            else if (sel_wr && ofs == OFS_CTRL)
                en <= wdata[CTRL_EN_BIT];
        end

        always_ff @(posedge clk)
        begin
            if (!rst_b)
                clr <= 1'b0;
            else if (sel_wr && ofs == OFS_CTRL)
                clr <= wdata[CTRL_CLR_BIT];
        end

        // --------------------------------------------------------
        // Prescale and match values
        // --------------------------------------------------------
        always_ff @(posedge clk)
        begin
            if (!rst_b)
                prescale <= '0;
            else if (sel_wr && ofs == OFS_PRESCALE)
                prescale <= wd;
        end

        always_ff @(posedge clk)
        begin
            if (!rst_b)
            begin
                for (int i = 0; i < MCCT_NUM_MATCH; i++)
                    match_val[i] <= '0;
            end
            else if (sel_wr)
            begin
                for (int i = 0; i < MCCT_NUM_MATCH; i++)
                    if (ofs == OFS_MATCH0 + 6'(4 * i))
                        match_val[i] <= wd;
            end
        end

        // --------------------------------------------------------
        // Option registers
        // --------------------------------------------------------
        always_ff @(posedge clk)
        begin
            if (!rst_b)
            begin
                match_ctl <= '0;
                cap_ctl <= CAP_CTL_RESET;
                ext_ctl <= '0;
            end
            else if (sel_wr)
            begin
                if (ofs == OFS_MATCH_CTL)
                    match_ctl <= wdata[11:0];
                if (ofs == OFS_CAP_CTL)
                    cap_ctl <= wdata[2:0];
                if (ofs == OFS_EXT_CTL)
                    ext_ctl <= wdata[7:0];
            end
        end

        // --------------------------------------------------------
        // Interrupt status and mask
        // --------------------------------------------------------
        assign sts_set = {capture_hit && cap_ctl[CAP_INT], match_hit & int_opt};

        // Set wins over a write-one-to-clear in the same cycle, so no event is lost.
        always_ff @(posedge clk)
        begin
            if (!rst_b)
                sts <= '0;
            else if (sel_wr && ofs == OFS_IRQ_STS)
                sts <= (sts & ~wdata[STS_W-1:0]) | sts_set;
            else
                sts <= sts | sts_set;
        end

        always_ff @(posedge clk)
        begin
            if (!rst_b)
                msk <= '0;
            else if (sel_wr && ofs == OFS_IRQ_MASK)
                msk <= wdata[STS_W-1:0];
        end

        assign inst_irq[g] = |(sts & msk);

        // --------------------------------------------------------
        // Counting engine
        // --------------------------------------------------------
        mcct_core #(
            .WIDTH(W),
            .NUM_MATCH(MCCT_NUM_MATCH)
        ) u_core (
            .clk(clk),
            .rst_b(rst_b),
            .run(en),
            .hold_clear(clr),
            .prescale_limit(prescale[W-1:0]),
            .match_value(match_flat),
            .match_ctl(match_ctl),
            .cap_edges(cap_ctl[1:0]),
            .ext_ctl(ext_ctl),
            .ext_load(ext_load),
            .ext_load_value(wdata[EXT_STATE_LSB +: MCCT_NUM_MATCH]),
            .capture_in(capture_in[g]),
            .count(count),
            .prescale_count(pre_count),
            .capture_value(cap_val),
            .match_hit(match_hit),
            .stop_hit(stop_hit),
            .capture_hit(capture_hit),
            .match_out(pin_state)
        );

        assign match_out[g*MCCT_NUM_MATCH +: MCCT_NUM_MATCH] = pin_state;

        // --------------------------------------------------------
        // Read decode
        // --------------------------------------------------------
        always_comb
        begin
            inst_rdata[g] = '0;
            case (ofs)
                OFS_CTRL: inst_rdata[g] = {30'h0, clr, en};
                OFS_COUNT: inst_rdata[g] = 32'(count);
                OFS_PRESCALE: inst_rdata[g] = prescale;
                OFS_PRE_COUNT: inst_rdata[g] = 32'(pre_count);
                OFS_MATCH_CTL: inst_rdata[g] = {20'h0, match_ctl};
                OFS_CAP_CTL: inst_rdata[g] = {29'h0, cap_ctl};
                OFS_CAPTURE: inst_rdata[g] = 32'(cap_val);
                OFS_EXT_CTL: inst_rdata[g] = {20'h0, pin_state, ext_ctl};
                OFS_IRQ_STS: inst_rdata[g] = {27'h0, sts};
                OFS_IRQ_MASK: inst_rdata[g] = {27'h0, msk};
                default:
                begin
                    for (int i = 0; i < MCCT_NUM_MATCH; i++)
                        if (ofs == OFS_MATCH0 + 6'(4 * i))
                            inst_rdata[g] = match_val[i];
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data and interrupt line
    // ------------------------------------------------------------
    // The fourth instance window is unmapped and reads as zero.
    always_comb
    begin
        next_rdata = '0;
        if (rd && inst_sel < 2'(MCCT_NUM_INST))
            next_rdata = inst_rdata[inst_sel];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rdata <= '0;
        else
            rdata <= next_rdata;
    end

    assign irq = |inst_irq;

endmodule

`default_nettype wire

// ---- design/mcct_pkg.sv ----
// Constants, register map and field layout of the match/capture counter-timer.
// Assumes one clock, a synchronous active-low reset and a plain strobe register port.
//
// Overview of operation
// - Three independent counter instances exist, two of 32 bits and one of 16 bits.
// - A counter advances on the system clock only while its enable bit is set.
// - Each counter is fed by a prescaler as wide as the counter, programmed by software.
// - An enabled capture-pin transition copies the counter value into a capture register.
// - A capture raises an interrupt only when its interrupt option is set, else it is silent.
// - Four match registers per instance are compared with the running count.
// - By default a match leaves the count running and may raise that channel's interrupt.
// - A match channel with its stop option halts the count on that match.
// - A match channel with its reset option clears the count to zero on that match.
// - Each match channel drives an output pin low, high, toggled or unchanged on a match.

package mcct_pkg;

    // ------------------------------------------------------------
    // Instances and widths
    // ------------------------------------------------------------
    localparam int MCCT_NUM_INST = 3;
    localparam int MCCT_NUM_MATCH = 4;
    localparam int MCCT_WIDE = 32;
    localparam int MCCT_NARROW = 16;
    localparam int MCCT_NARROW_INST = 2;
    localparam int MCCT_ADDR_W = 8;
    localparam int MCCT_INST_LSB = 6;

    // ------------------------------------------------------------
    // Register offsets within one instance window
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_COUNT = 6'h04;
    localparam logic [5:0] OFS_PRESCALE = 6'h08;
    localparam logic [5:0] OFS_PRE_COUNT = 6'h0C;
    localparam logic [5:0] OFS_MATCH_CTL = 6'h10;
    localparam logic [5:0] OFS_MATCH0 = 6'h14;
    localparam logic [5:0] OFS_CAP_CTL = 6'h24;
    localparam logic [5:0] OFS_CAPTURE = 6'h28;
    localparam logic [5:0] OFS_EXT_CTL = 6'h2C;
    localparam logic [5:0] OFS_IRQ_STS = 6'h30;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h34;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int MCTL_W = 3;
    localparam int MCTL_INT = 0;
    localparam int MCTL_RESET = 1;
    localparam int MCTL_STOP = 2;
    localparam int CAP_RISE = 0;
    localparam int CAP_FALL = 1;
    localparam int CAP_INT = 2;
    localparam logic [2:0] CAP_CTL_RESET = 3'h3;
    localparam int EXT_W = 2;
    localparam int EXT_STATE_LSB = 8;
    localparam int STS_W = 5;
    localparam int STS_CAP_BIT = 4;

    typedef enum logic [1:0] {
        MCCT_EXT_NOTHING,
        MCCT_EXT_LOW,
        MCCT_EXT_HIGH,
        MCCT_EXT_TOGGLE
    } mcct_ext_act_t;

    // Pick one option bit of match channel ch out of a packed control word.
    function automatic logic mcct_mctl_bit(input logic [11:0] ctl, input int ch, input int pos);
        return ctl[ch * MCTL_W + pos];
    endfunction

    // Keeps register writes within the counter width of an instance.
    function automatic logic [31:0] mcct_width_mask(input int w);
        return (w >= 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
    endfunction

endpackage

// ---- design/mcct_core.sv ----
// Counting engine of one counter-timer instance: prescaler, counter, match, capture, outputs.
// Assumes its controls come from registers in the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module mcct_core #(
    parameter int WIDTH = 32,
    parameter int NUM_MATCH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic hold_clear,
    input wire logic [WIDTH-1:0] prescale_limit,
    input wire logic [NUM_MATCH*WIDTH-1:0] match_value,
    input wire logic [11:0] match_ctl,
    input wire logic [1:0] cap_edges,
    input wire logic [NUM_MATCH*2-1:0] ext_ctl,
    input wire logic ext_load,
    input wire logic [NUM_MATCH-1:0] ext_load_value,
    input wire logic capture_in,
    output logic [WIDTH-1:0] count,
    output logic [WIDTH-1:0] prescale_count,
    output logic [WIDTH-1:0] capture_value,
    output logic [NUM_MATCH-1:0] match_hit,
    output logic stop_hit,
    output logic capture_hit,
    output logic [NUM_MATCH-1:0] match_out
);
    import mcct_pkg::*;

    logic tick;
    logic reset_hit;
    logic cap_prev;
    logic [NUM_MATCH-1:0] reset_sel;
    logic [NUM_MATCH-1:0] stop_sel;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    assign tick = run && !hold_clear && (prescale_count == prescale_limit);

    always_ff @(posedge clk)
    begin
        if (!rst_b || hold_clear)
            prescale_count <= '0;
        else if (tick)
            prescale_count <= '0;
        else if (run)
            prescale_count <= prescale_count + WIDTH'(1);
    end

    // ------------------------------------------------------------
    // Match compare
    // ------------------------------------------------------------
    // Compare is qualified by the tick, so a match acts once per counter clock even when
    // the prescaler holds the count at one value for many system cycles.
    for (genvar i = 0; i < NUM_MATCH; i++)
    begin : g_match
        assign match_hit[i] = tick && (count == match_value[i*WIDTH +: WIDTH]);
        assign reset_sel[i] = match_hit[i] && mcct_mctl_bit(match_ctl, i, MCTL_RESET);
        assign stop_sel[i] = match_hit[i] && mcct_mctl_bit(match_ctl, i, MCTL_STOP);
    end

    assign reset_hit = |reset_sel;
    assign stop_hit = |stop_sel;

    // ------------------------------------------------------------
    // Main counter
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_b || hold_clear)
            count <= '0;
        else if (tick)
        begin
            if (reset_hit)
                count <= '0;
            else if (!stop_hit)
                count <= count + WIDTH'(1);
        end
    end

    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    assign capture_hit = (cap_edges[CAP_RISE] && capture_in && !cap_prev)
        || (cap_edges[CAP_FALL] && !capture_in && cap_prev);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cap_prev <= 1'b0;
        else
            cap_prev <= capture_in;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            capture_value <= '0;
        else if (capture_hit)
            capture_value <= count;
    end

    // ------------------------------------------------------------
    // External match outputs
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_MATCH; i++)
    begin : g_ext
        always_ff @(posedge clk)
        begin
            if (!rst_b)
                match_out[i] <= 1'b0;
            else if (match_hit[i])
            begin
                case (mcct_ext_act_t'(ext_ctl[i*2 +: 2]))
                    MCCT_EXT_LOW: match_out[i] <= 1'b0;
                    MCCT_EXT_HIGH: match_out[i] <= 1'b1;
                    MCCT_EXT_TOGGLE: match_out[i] <= !match_out[i];
                    default: match_out[i] <= match_out[i];
                endcase
            end
            else if (ext_load)
                match_out[i] <= ext_load_value[i];
        end
    end

endmodule

`default_nettype wire

// ---- verification/mcct_assertions.sv ----
// Checker for the counter-timer register port and pins.
// Assumes it is bound to mcct_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module mcct_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [mcct_pkg::MCCT_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [mcct_pkg::MCCT_NUM_INST-1:0] capture_in,
    input wire logic [11:0] match_out,
    input wire logic irq
);
    import mcct_pkg::*;
    logic [3:0] pins_sel;
    logic [5:0] ofs;
    assign ofs = addr[5:0];
    // The pin group follows the addressed instance so the read-back can be compared.
    always_comb
    begin
        case (addr[7:6])
            2'h0: pins_sel = match_out[3:0];
            2'h1: pins_sel = match_out[7:4];
            default: pins_sel = match_out[11:8];
        endcase
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    idle_rdata_a: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero after idle cycle");
    no_inst_a: assert property (rd && addr[7:6] == 2'h3 |=> rdata == 32'h0)
        else $error("unmapped instance read not zero");
    no_ofs_a: assert property (rd && ofs >= 6'h38 |=> rdata == 32'h0)
        else $error("unmapped offset read not zero");
    narrow_read_a: assert property (rd && addr[7:6] == 2'h2 && (ofs == OFS_COUNT
        || ofs == OFS_PRESCALE || ofs == OFS_CAPTURE || ofs == OFS_PRE_COUNT)
        |=> rdata[31:16] == 16'h0)
        else $error("narrow instance read above bit 15");
    ctrl_bits_a: assert property (rd && ofs == OFS_CTRL |=> rdata[31:2] == 30'h0)
        else $error("control read has stray bits");
    mctl_bits_a: assert property (rd && ofs == OFS_MATCH_CTL |=> rdata[31:12] == 20'h0)
        else $error("match control read has stray bits");
    cap_bits_a: assert property (rd && ofs == OFS_CAP_CTL |=> rdata[31:3] == 29'h0)
        else $error("capture control read has stray bits");
    pin_state_a: assert property (rd && addr[7:6] != 2'h3 && ofs == OFS_EXT_CTL
        |=> rdata[11:8] == $past(pins_sel))
        else $error("pin state read-back differs from pins");
endmodule
`default_nettype wire

// ---- verification/mcct_pin_partner.sv ----
// Model of the capture pins and match pins around the counter-timer.
// Assumes the bench calls pulse to make a capture pin transition.
`timescale 1ns/1ps
`default_nettype none

module mcct_pin_partner (
    input wire logic clk,
    output logic [2:0] capture_in,
    input wire logic [11:0] match_out
);
    logic [11:0] seen_pins;
    initial capture_in = 3'h0;
    always @(posedge clk) seen_pins <= match_out;
    // A rise and a fall, each held for a few cycles so both edges are seen.
    // Static on purpose: the pin index is used on the left of a non-blocking assignment.
    task pulse(input int g);
        @(posedge clk);
        capture_in[g] <= 1'b1;
        repeat (3) @(posedge clk);
        capture_in[g] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the three-instance counter-timer.
// Assumes the checker and the pin model sit beside the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) \
    begin checks_done++; if ((act) !== (exp)) begin fails++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end

module tb_top;
    import mcct_pkg::*;
    logic clk;
    logic rst_b;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [2:0] capture_in;
    logic [11:0] match_out;
    logic irq;
    logic [31:0] d;
    int fails;
    int checks_done;
    int cycles;
    always #4 clk = ~clk;
    mcct_top dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .capture_in(capture_in), .match_out(match_out), .irq(irq));
    mcct_pin_partner pins (.clk(clk), .capture_in(capture_in), .match_out(match_out));

    // Writes hold one cycle idle after the strobe so no strobe is driven twice in a step.
    task automatic wr_reg(input logic [1:0] g, input logic [5:0] o, input logic [31:0] v);
        addr <= {g, o};
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [1:0] g, input logic [5:0] o, output logic [31:0] v);
        addr <= {g, o};
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        @(posedge clk);
    endtask
    task automatic expect_reg(input logic [1:0] g, input logic [5:0] o, input logic [31:0] e);
        rd_reg(g, o, d);
        `CHK(d, e)
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic t_map;
        expect_reg(2'h0, OFS_CAP_CTL, 32'h3);
        wr_reg(2'h0, OFS_MATCH_CTL, 32'hFFFFFFFF);
        expect_reg(2'h0, OFS_MATCH_CTL, 32'hFFF);
        wr_reg(2'h0, OFS_MATCH_CTL, 32'h0);
        wr_reg(2'h2, OFS_PRESCALE, 32'hFFFFFFFF);
        expect_reg(2'h2, OFS_PRESCALE, 32'hFFFF);
        wr_reg(2'h2, OFS_PRESCALE, 32'h0);
        wr_reg(2'h3, OFS_CTRL, 32'h1);
        expect_reg(2'h3, OFS_CTRL, 32'h0);
        expect_reg(2'h0, 6'h38, 32'h0);
        $display("test map done");
    endtask

    // Ten enabled edges with limit 3 give two ticks and a prescaler left at 2.
    task automatic t_prescale;
        wr_reg(2'h0, OFS_PRESCALE, 32'h3);
        wr_reg(2'h0, OFS_CTRL, 32'h1);
        repeat (8) @(posedge clk);
        wr_reg(2'h0, OFS_CTRL, 32'h0);
        expect_reg(2'h0, OFS_COUNT, 32'h2);
        expect_reg(2'h0, OFS_PRE_COUNT, 32'h2);
        expect_reg(2'h0, OFS_COUNT, 32'h2);
        wr_reg(2'h0, OFS_CTRL, 32'h2);
        expect_reg(2'h0, OFS_PRE_COUNT, 32'h0);
        $display("test prescale done");
    endtask

    // Period six from the reset match: after 22 ticks the count is 4.
    task automatic t_reset_match;
        wr_reg(2'h1, OFS_MATCH0, 32'h5);
        wr_reg(2'h1, OFS_MATCH0 + 6'h4, 32'h3);
        wr_reg(2'h1, OFS_MATCH_CTL, 32'hB);
        wr_reg(2'h1, OFS_IRQ_MASK, 32'h3);
        wr_reg(2'h1, OFS_CTRL, 32'h1);
        repeat (20) @(posedge clk);
        wr_reg(2'h1, OFS_CTRL, 32'h0);
        expect_reg(2'h1, OFS_COUNT, 32'h4);
        expect_reg(2'h1, OFS_IRQ_STS, 32'h3);
        `CHK(irq, 1'b1)
        wr_reg(2'h1, OFS_IRQ_MASK, 32'h0);
        `CHK(irq, 1'b0)
        wr_reg(2'h1, OFS_IRQ_STS, 32'h3);
        wr_reg(2'h1, OFS_IRQ_MASK, 32'h3);
        expect_reg(2'h1, OFS_IRQ_STS, 32'h0);
        $display("test reset match done");
    endtask

    // Pins load 1100; toggle, high, low, nothing leave 1011 once the stop match ends the run.
    task automatic t_stop_pins;
        wr_reg(2'h0, OFS_PRESCALE, 32'h0);
        for (int i = 0; i < 4; i++)
            wr_reg(2'h0, OFS_MATCH0 + 6'(4 * i), (i == 0) ? 32'h4 : 32'(i));
        wr_reg(2'h0, OFS_MATCH_CTL, 32'h4);
        wr_reg(2'h0, OFS_EXT_CTL, 32'hC1B);
        `CHK(match_out[3:0], 4'hC)
        wr_reg(2'h0, OFS_CTRL, 32'h1);
        repeat (12) @(posedge clk);
        expect_reg(2'h0, OFS_COUNT, 32'h4);
        expect_reg(2'h0, OFS_CTRL, 32'h0);
        expect_reg(2'h0, OFS_EXT_CTL, 32'hB1B);
        `CHK(match_out, 12'h00B)
        `CHK(pins.seen_pins, 12'h00B)
        $display("test stop pins done");
    endtask

    task automatic t_capture;
        logic [31:0] c;
        wr_reg(2'h2, OFS_CAP_CTL, 32'h5);
        wr_reg(2'h2, OFS_IRQ_MASK, 32'h10);
        for (int k = 0; k < 2; k++)
        begin
            wr_reg(2'h2, OFS_CTRL, 32'h1);
            repeat (3 + k) @(posedge clk);
            wr_reg(2'h2, OFS_CTRL, 32'h0);
            rd_reg(2'h2, OFS_COUNT, c);
            pins.pulse(2);
            expect_reg(2'h2, OFS_CAPTURE, c);
            expect_reg(2'h2, OFS_IRQ_STS, (k == 0) ? 32'h10 : 32'h0);
            `CHK(irq, (k == 0))
            wr_reg(2'h2, OFS_IRQ_STS, 32'h10);
            wr_reg(2'h2, OFS_CAP_CTL, 32'h2);
        end
        $display("test capture done");
    endtask

    // A reset in mid-run must bring pins, options and counts back to their reset values.
    task automatic t_mid_reset;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        `CHK(match_out, 12'h000)
        `CHK(irq, 1'b0)
        expect_reg(2'h2, OFS_CAP_CTL, 32'h3);
        expect_reg(2'h0, OFS_COUNT, 32'h0);
        $display("test mid reset done");
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            $display("timeout");
            end_sim();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_map();
        t_prescale();
        t_reset_match();
        t_stop_pins();
        t_capture();
        t_mid_reset();
        end_sim();
    end
endmodule

bind mcct_top mcct_assertions chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .capture_in(capture_in), .match_out(match_out), .irq(irq));
`default_nettype wire
